// ---- twowire_pkg.sv ----
package twowire_pkg;

  // ------------------------------------------------------------
  // Bus addressing
  // ------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h40;
  localparam int PTR_W = 8;
  localparam int DATA_W = 8;
  localparam int BIT_MSB = 7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 200;
  localparam int SDA_HOLD_NS = 300;
  // Least time: round up
  localparam int SDA_HOLD_CYC = (SDA_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int SCL_HALF_CYC_DEF = 16;

  // ------------------------------------------------------------
  // Link states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_ADDR = 3'b001,
    T_ADDR_ACK = 3'b010,
    T_RX = 3'b011,
    T_RX_ACK = 3'b100,
    T_TX = 3'b101,
    T_TX_ACK = 3'b110
  } tgt_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0000,
    H_START = 4'b0001,
    H_BIT_LO = 4'b0010,
    H_BIT_HI = 4'b0011,
    H_ACK_LO = 4'b0100,
    H_ACK_HI = 4'b0101,
    H_STOP_LO = 4'b0110,
    H_STOP_HI = 4'b0111,
    H_STOP_END = 4'b1000
  } host_state_t;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = p + 8'h01;
  endfunction

endpackage

// ---- twowire_if.sv ----
`timescale 1ns/100ps
interface twowire_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_tgt_o;
  logic sda_tgt_oe;
  logic scl_i;
  logic sda_i;

  // ------------------------------------------------------------
  // Wired-AND with pull-up
  // ------------------------------------------------------------
  assign scl_i = ~(scl_oe & ~scl_o);
  assign sda_i = ~((sda_host_oe & ~sda_host_o) | (sda_tgt_oe & ~sda_tgt_o));

  modport host (output scl_o, output scl_oe, output sda_host_o, output sda_host_oe,
                input scl_i, input sda_i);
  modport target (output sda_tgt_o, output sda_tgt_oe, input scl_i, input sda_i);
endinterface

// ---- twowire_host.sv ----
`timescale 1ns/100ps
// Controller end: generates every clock, START and STOP; one byte per command.
module twowire_host #(
  parameter int HALF_CYC = twowire_pkg::SCL_HALF_CYC_DEF
) (
  input wire logic CLK,
  input wire logic ARST_N,
  twowire_if.host BUS,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_START,
  input wire logic CMD_STOP,
  input wire logic CMD_READ,
  input wire logic CMD_ACK,
  input wire logic [twowire_pkg::DATA_W-1:0] CMD_DATA,
  output logic RSP_VALID,
  output logic [twowire_pkg::DATA_W-1:0] RSP_DATA,
  output logic RSP_ACK
);
  import twowire_pkg::*;

  // Data moves mid low phase, clear of both clock edges, so the
  // target's delayed data view never meets a rising clock
  localparam int SETUP_CYC = HALF_CYC / 2;

  initial begin
    if (HALF_CYC < 4 || HALF_CYC > 65535) $error("HALF_CYC out of range");
  end

  host_state_t state_reg;
  logic [15:0] tick_reg;
  logic tick;
  logic [3:0] bit_reg;
  logic [DATA_W-1:0] sh_reg;
  logic rd_reg, ack_reg, stop_reg;
  logic scl_reg, sda_reg;
  logic sda_m, sda_s;

  // ------------------------------------------------------------
  // Sync and divider
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= BUS.sda_i;
      sda_s <= sda_m;
    end
  end

  assign tick = (tick_reg == 16'(HALF_CYC - 1));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) tick_reg <= 16'h0000;
    else if (state_reg == H_IDLE || tick) tick_reg <= 16'h0000;
    else tick_reg <= tick_reg + 16'h0001;
  end

  assign CMD_READY = (state_reg == H_IDLE);
  assign BUS.scl_o = 1'b0;
  assign BUS.scl_oe = ~scl_reg;
  assign BUS.sda_host_o = 1'b0;
  assign BUS.sda_host_oe = ~sda_reg;

  // ------------------------------------------------------------
  // Byte sequencer
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= H_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
      stop_reg <= 1'b0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      RSP_ACK <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (CMD_VALID) begin
            sh_reg <= CMD_DATA;
            rd_reg <= CMD_READ;
            ack_reg <= CMD_ACK;
            stop_reg <= CMD_STOP;
            bit_reg <= BIT_FIRST;
            if (CMD_START) begin
              // Repeated START: raise SDA while SCL low, then SCL
              sda_reg <= 1'b1;
              state_reg <= H_START;
            end else begin
              state_reg <= H_BIT_LO;
            end
          end
        end
        H_START: if (tick) begin
          if (!scl_reg) scl_reg <= 1'b1;
          else if (sda_reg) sda_reg <= 1'b0;
          else begin
            scl_reg <= 1'b0;
            state_reg <= H_BIT_LO;
          end
        end
        H_BIT_LO: begin
          if (tick_reg == 16'(SETUP_CYC)) sda_reg <= rd_reg ? 1'b1 : sh_reg[BIT_MSB];
          if (tick) begin
            scl_reg <= 1'b1;
            state_reg <= H_BIT_HI;
          end
        end
        H_BIT_HI: if (tick) begin
          scl_reg <= 1'b0;
          sh_reg <= {sh_reg[DATA_W-2:0], sda_s};
          if (bit_reg == 4'(BIT_MSB)) state_reg <= H_ACK_LO;
          else begin
            bit_reg <= bit_reg + 4'h1;
            state_reg <= H_BIT_LO;
          end
        end
        H_ACK_LO: begin
          if (tick_reg == 16'(SETUP_CYC)) sda_reg <= rd_reg ? ~ack_reg : 1'b1;
          if (tick) begin
            scl_reg <= 1'b1;
            state_reg <= H_ACK_HI;
          end
        end
        H_ACK_HI: if (tick) begin
          scl_reg <= 1'b0;
          RSP_VALID <= 1'b1;
          RSP_DATA <= sh_reg;
          RSP_ACK <= rd_reg ? ack_reg : ~sda_s;
          state_reg <= stop_reg ? H_STOP_LO : H_IDLE;
        end
        H_STOP_LO: if (tick) begin
          sda_reg <= 1'b0;
          state_reg <= H_STOP_HI;
        end
        H_STOP_HI: if (tick) begin
          scl_reg <= 1'b1;
          state_reg <= H_STOP_END;
        end
        H_STOP_END: if (tick) begin
          sda_reg <= 1'b1;
          state_reg <= H_IDLE;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end
endmodule

// ---- twowire_target.sv ----
`timescale 1ns/100ps
// Behaviour
// - Target only, never holds clock low
// - Controller makes all clocks, START, STOP
// - Pointer advances after every data byte except the pointer load
// - Invalid pointer load is NACKed, transfer continues
// - Invalid location reads as zero
// - Invalid writes NACKed, valid again ACKed
// - Pointer wraps across whole address space
// - Transfer starts on any START, repeated START included
// - START is SDA fall while SCL high
// - STOP is SDA rise while SCL high
// - SDA changes only while SCL low
// - Eight bits per byte, ninth bit acknowledge
// - Unlimited bytes between START and STOP
// - Delayed SDA view for START/STOP detection
// - Address select pin picks one of two
// - First written byte loads pointer
// - Writes to invalid locations are discarded
// - Reads start at current pointer
module twowire_target #(
  parameter int HOLD_CYC = twowire_pkg::SDA_HOLD_CYC,
  parameter int BUF_DEPTH = 2
) (
  input wire logic CLK,
  input wire logic ARST_N,
  twowire_if.target BUS,
  input wire logic ADDR_SEL,
  output logic [twowire_pkg::PTR_W-1:0] REG_PTR,
  input wire logic REG_VALID,
  input wire logic [twowire_pkg::DATA_W-1:0] REG_RDATA,
  output logic WR_VALID,
  input wire logic WR_READY,
  output logic [twowire_pkg::PTR_W-1:0] WR_ADDR,
  output logic [twowire_pkg::DATA_W-1:0] WR_DATA,
  output logic BUSY
);
  import twowire_pkg::*;

  initial begin
    if (HOLD_CYC < 2 || HOLD_CYC > 255) $error("HOLD_CYC out of range");
    if (BUF_DEPTH != 2) $error("BUF_DEPTH must be 2");
  end

  // ------------------------------------------------------------
  // Input sampling and SDA hold delay
  // ------------------------------------------------------------
  logic scl_m, scl_s, scl_d, sda_m, sda_s;
  logic sel_m, sel_s;
  logic [HOLD_CYC-1:0] sda_dly;
  logic sda_v, sda_v_d;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_dly <= '1;
      sda_v_d <= 1'b1;
      sel_m <= 1'b0;
      sel_s <= 1'b0;
    end else begin
      scl_m <= BUS.scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= BUS.sda_i;
      sda_s <= sda_m;
      // Strap pin is asynchronous too
      sel_m <= ADDR_SEL;
      sel_s <= sel_m;
      // Delay bridges SCL fall slope so a late edge is not a START/STOP
      sda_dly <= {sda_dly[HOLD_CYC-2:0], sda_s};
      sda_v_d <= sda_v;
    end
  end
  assign sda_v = sda_dly[HOLD_CYC-1];

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_v_d & ~sda_v;
  assign stop_c = scl_s & scl_d & ~sda_v_d & sda_v;

  // ------------------------------------------------------------
  // Protocol engine
  // ------------------------------------------------------------
  tgt_state_t state_reg;
  logic [3:0] bit_reg;
  logic [DATA_W-1:0] sh_reg;
  logic [PTR_W-1:0] ptr_reg;
  logic first_reg, drive_reg, out_reg, ack_reg, busy_reg;
  logic push;
  logic [1:0] cnt_reg;
  logic [PTR_W-1:0] buf_a [0:1];
  logic [DATA_W-1:0] buf_d [0:1];
  logic wr_idx, rd_idx;
  logic buf_ready;

  assign buf_ready = (cnt_reg != 2'(BUF_DEPTH));
  assign REG_PTR = ptr_reg;
  assign BUSY = busy_reg;
  // Open drain: only ever pulls SDA, SCL is never touched
  assign BUS.sda_tgt_o = 1'b0;
  assign BUS.sda_tgt_oe = drive_reg & ~out_reg;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) busy_reg <= 1'b0;
    else if (start_c) busy_reg <= 1'b1;
    else if (stop_c) busy_reg <= 1'b0;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= T_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      first_reg <= 1'b0;
      drive_reg <= 1'b0;
      out_reg <= 1'b1;
      ack_reg <= 1'b0;
      push <= 1'b0;
    end else begin
      push <= 1'b0;
      if (start_c) begin
        state_reg <= T_ADDR;
        bit_reg <= BIT_FIRST;
        drive_reg <= 1'b0;
      end else if (stop_c) begin
        state_reg <= T_IDLE;
        drive_reg <= 1'b0;
      end else begin
        case (state_reg)
          T_IDLE: drive_reg <= 1'b0;
          T_ADDR, T_RX: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[DATA_W-2:0], sda_s};
              bit_reg <= bit_reg + 4'h1;
            end
            if (scl_fall && bit_reg == ACK_SLOT) begin
              bit_reg <= BIT_FIRST;
              if (state_reg == T_ADDR) begin
                if (sh_reg[DATA_W-1:1] == (TARGET_ADDR_BASE | {6'h00, sel_s})) begin
                  drive_reg <= 1'b1;
                  out_reg <= 1'b0;
                  first_reg <= ~sh_reg[0];
                  state_reg <= T_ADDR_ACK;
                  ack_reg <= sh_reg[0];
                end else begin
                  state_reg <= T_IDLE;
                end
              end else begin
                state_reg <= T_RX_ACK;
                drive_reg <= 1'b1;
                if (first_reg) begin
                  ptr_reg <= sh_reg;
                  out_reg <= 1'b1; // decided in ack slot below
                end else begin
                  // Back-pressure: a full buffer NACKs too, no word lost
                  out_reg <= ~(REG_VALID & buf_ready);
                  push <= REG_VALID & buf_ready;
                end
              end
            end
          end
          T_ADDR_ACK, T_RX_ACK: begin
            if (state_reg == T_RX_ACK && first_reg && scl_rise == 1'b0 && scl_s == 1'b0) begin
              out_reg <= ~REG_VALID;
            end
            if (scl_fall) begin
              if (state_reg == T_RX_ACK) begin
                if (first_reg) first_reg <= 1'b0;
                else ptr_reg <= ptr_inc(ptr_reg);
                drive_reg <= 1'b0;
                state_reg <= T_RX;
              end else if (ack_reg) begin
                sh_reg <= REG_VALID ? REG_RDATA : 8'h00;
                out_reg <= REG_VALID ? REG_RDATA[BIT_MSB] : 1'b0;
                state_reg <= T_TX;
              end else begin
                drive_reg <= 1'b0;
                state_reg <= T_RX;
              end
            end
          end
          T_TX: begin
            if (scl_fall) begin
              if (bit_reg == 4'(BIT_MSB)) begin
                drive_reg <= 1'b0;
                bit_reg <= BIT_FIRST;
                ptr_reg <= ptr_inc(ptr_reg);
                state_reg <= T_TX_ACK;
              end else begin
                bit_reg <= bit_reg + 4'h1;
                sh_reg <= {sh_reg[DATA_W-2:0], 1'b0};
                out_reg <= sh_reg[DATA_W-2];
              end
            end
          end
          T_TX_ACK: begin
            if (scl_rise) ack_reg <= ~sda_s;
            if (scl_fall) begin
              if (ack_reg) begin
                drive_reg <= 1'b1;
                sh_reg <= REG_VALID ? REG_RDATA : 8'h00;
                out_reg <= REG_VALID ? REG_RDATA[BIT_MSB] : 1'b0;
                state_reg <= T_TX;
              end else begin
                state_reg <= T_IDLE;
              end
            end
          end
          default: state_reg <= T_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Two-entry write buffer
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_reg <= 2'h0;
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
    end else begin
      if (push) wr_idx <= ~wr_idx;
      if (WR_VALID && WR_READY) rd_idx <= ~rd_idx;
      cnt_reg <= cnt_reg + 2'(push) - 2'(WR_VALID && WR_READY);
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      buf_a[wr_idx] <= ptr_reg;
      buf_d[wr_idx] <= sh_reg;
    end
  end

  assign WR_VALID = (cnt_reg != 2'h0);
  assign WR_ADDR = buf_a[rd_idx];
  assign WR_DATA = buf_d[rd_idx];
endmodule

// ---- i2c_target_register_port_assertions.sv ----
`timescale 1ns/100ps
module i2c_target_register_port_assertions (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_tgt_o,
  input wire logic sda_tgt_oe,
  input wire logic scl_i,
  input wire logic sda_i
);
  logic scl_q;
  logic sda_q;
  logic idle_reg;
  logic [3:0] bit_cnt_reg;
  logic start_seen;
  logic stop_seen;
  logic tgt_pull;

  // ------------------------------------------------------------
  // Line conditions
  // ------------------------------------------------------------
  assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_seen = scl_i & scl_q & ~sda_q & sda_i;
  assign tgt_pull = sda_tgt_oe & ~sda_tgt_o;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Rises since START; a framing condition is legal only on the first pulse of a slot
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_cnt_reg <= 4'h1;
    end else if (start_seen) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_i & ~scl_q) begin
      bit_cnt_reg <= (bit_cnt_reg == 4'h9) ? 4'h1 : bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      idle_reg <= 1'h1;
    end else if (stop_seen) begin
      idle_reg <= 1'h1;
    end else if (start_seen) begin
      idle_reg <= 1'h0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  scl_high_len_a: assert property ($rose(scl_i) |-> scl_i [*8])
    else $error("clock high phase too short");
  start_by_host_a: assert property (start_seen |-> sda_host_oe && !sda_host_o)
    else $error("start not made by host");
  stop_by_host_a: assert property (stop_seen |-> $past(sda_host_oe) && !$past(sda_host_o))
    else $error("stop not made by host");
  tgt_stable_a: assert property (scl_i && scl_q |-> $stable(tgt_pull))
    else $error("target data moved while clock high");
  start_on_slot_a: assert property (start_seen |-> bit_cnt_reg == 4'h1)
    else $error("start in mid byte");
  stop_on_slot_a: assert property (stop_seen |-> bit_cnt_reg == 4'h1)
    else $error("stop in mid byte");
  idle_scl_a: assert property (idle_reg |-> scl_i)
    else $error("clock low while bus idle");
  idle_release_a: assert property (idle_reg |-> !tgt_pull)
    else $error("target holds data line while idle");
endmodule

// ---- i2c_target_register_port_test.sv ----
`timescale 1ns/100ps
module i2c_target_register_port_test;
  import twowire_pkg::*;
  // Hold shortened: must stay below the scaled clock low phase
  localparam int HOLD = 4;
  localparam int LIMIT = 40000;
  localparam logic [7:0] AW = {TARGET_ADDR_BASE, 1'h0};
  localparam logic [7:0] AR = {TARGET_ADDR_BASE, 1'h1};
  logic clk, arst_n, cmd_valid, cmd_ready, cmd_start, cmd_stop, cmd_read, cmd_ack;
  logic [7:0] cmd_data, rsp_data, reg_ptr, reg_rdata, wr_addr, wr_data;
  logic rsp_valid, rsp_ack, addr_sel, reg_valid, wr_valid, wr_ready, busy;
  logic [7:0] mem [256];
  int miscompares, num_checks, cyc;

  twowire_if bus ();
  twowire_host #(.HALF_CYC(16)) u_twowire_host (.CLK(clk), .ARST_N(arst_n), .BUS(bus),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_START(cmd_start), .CMD_STOP(cmd_stop),
    .CMD_READ(cmd_read), .CMD_ACK(cmd_ack), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .RSP_ACK(rsp_ack));
  twowire_target #(.HOLD_CYC(HOLD), .BUF_DEPTH(2)) u_twowire_target (.CLK(clk),
    .ARST_N(arst_n), .BUS(bus), .ADDR_SEL(addr_sel), .REG_PTR(reg_ptr), .REG_VALID(reg_valid),
    .REG_RDATA(reg_rdata), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .BUSY(busy));
  i2c_target_register_port_assertions u_i2c_target_register_port_assertions (.CLK(clk),
    .ARST_N(arst_n), .scl_o(bus.scl_o), .scl_oe(bus.scl_oe), .sda_host_o(bus.sda_host_o),
    .sda_host_oe(bus.sda_host_oe), .sda_tgt_o(bus.sda_tgt_o), .sda_tgt_oe(bus.sda_tgt_oe),
    .scl_i(bus.scl_i), .sda_i(bus.sda_i));

  // ------------------------------------------------------------
  // Register side model
  // ------------------------------------------------------------
  function automatic logic vld(input logic [7:0] p);
    return p < 8'h10 || p >= 8'hFC;
  endfunction
  assign reg_valid = vld(reg_ptr);
  // Invalid places offer noise; the target must send zero instead
  assign reg_rdata = reg_valid ? mem[reg_ptr] : 8'hA5;

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (wr_valid === 1'h1 && wr_ready === 1'h1) begin
      chk("wr_place", 8'h01, {7'h00, vld(wr_addr)});
      mem[wr_addr] <= wr_data;
    end
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Flags: start, stop, read, ack; e is read data or expected ack
  task automatic op(input logic [3:0] f, input logic [7:0] d, input logic [7:0] e);
    {cmd_start, cmd_stop, cmd_read, cmd_ack} = f;
    cmd_data = d;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'h0;
    while (rsp_valid !== 1'h1) @(negedge clk);
    if (f[1]) chk("rd_data", e, rsp_data);
    else chk("ack", e, {7'h00, rsp_ack});
  endtask

  // Lets the STOP finish and pass the target's hold delay
  task automatic settle();
    while (cmd_ready !== 1'h1) @(negedge clk);
    repeat (HOLD + 4) @(negedge clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'h0;
    arst_n = 1'h0;
    cmd_valid = 1'h0;
    {cmd_start, cmd_stop, cmd_read, cmd_ack} = 4'h0;
    cmd_data = 8'h00;
    addr_sel = 1'h0;
    wr_ready = 1'h1;
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    repeat (20) @(negedge clk);
    arst_n = 1'h1;
    @(negedge clk);
    chk("ptr", 8'h00, reg_ptr);
    op(4'h8, AW, 8'h01);
    op(4'h0, 8'h0E, 8'h01);
    op(4'h0, 8'h11, 8'h01);
    op(4'h0, 8'h22, 8'h01);
    op(4'h4, 8'h33, 8'h00);
    settle();
    chk("busy", 8'h00, {7'h00, busy});
    chk("ptr", 8'h11, reg_ptr);
    $display("test write_tail done");
    op(4'h8, AW, 8'h01);
    op(4'h0, 8'h80, 8'h00);
    op(4'h4, 8'h44, 8'h00);
    settle();
    chk("ptr", 8'h81, reg_ptr);
    $display("test bad_pointer done");
    op(4'h8, AW, 8'h01);
    op(4'h0, 8'hFE, 8'h01);
    op(4'h0, 8'h55, 8'h01);
    op(4'h0, 8'h66, 8'h01);
    op(4'h0, 8'h77, 8'h01);
    op(4'h4, 8'h88, 8'h01);
    settle();
    op(4'h8, AR, 8'h01);
    op(4'h3, 8'h00, 8'h58);
    op(4'h6, 8'h00, 8'h59);
    settle();
    chk("ptr", 8'h04, reg_ptr);
    $display("test wrap_and_current done");
    op(4'h8, AW, 8'h01);
    op(4'h0, 8'h0E, 8'h01);
    op(4'h8, AR, 8'h01);
    chk("busy", 8'h01, {7'h00, busy});
    op(4'h3, 8'h00, 8'h11);
    op(4'h3, 8'h00, 8'h22);
    op(4'h3, 8'h00, 8'h00);
    op(4'h6, 8'h00, 8'h00);
    settle();
    op(4'h8, AW, 8'h01);
    op(4'h0, 8'hFE, 8'h01);
    op(4'h8, AR, 8'h01);
    op(4'h3, 8'h00, 8'h55);
    op(4'h3, 8'h00, 8'h66);
    op(4'h3, 8'h00, 8'h77);
    op(4'h6, 8'h00, 8'h88);
    settle();
    $display("test read_back done");
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 2; a++) begin
        addr_sel = s[0];
        op(4'hC, {TARGET_ADDR_BASE | 7'(a), 1'h0}, {7'h00, 1'(a == s)});
        settle();
      end
    end
    addr_sel = 1'h0;
    $display("test address_select done");
    wr_ready = 1'h0;
    op(4'h8, AW, 8'h01);
    op(4'h0, 8'h00, 8'h01);
    op(4'h0, 8'hAA, 8'h01);
    op(4'h0, 8'hBB, 8'h01);
    op(4'h4, 8'hCC, 8'h00);
    settle();
    chk("wr_valid", 8'h01, {7'h00, wr_valid});
    wr_ready = 1'h1;
    repeat (8) @(negedge clk);
    op(4'h8, AW, 8'h01);
    op(4'h0, 8'h00, 8'h01);
    op(4'h8, AR, 8'h01);
    op(4'h3, 8'h00, 8'hAA);
    op(4'h3, 8'h00, 8'hBB);
    op(4'h6, 8'h00, 8'h58);
    settle();
    $display("test write_stall done");
    report_and_stop();
  end
endmodule
